/* logic/asrc_consts.vh */
`ifndef ASRC_CONSTS_VH
`define ASRC_CONSTS_VH
// Clock period in picoseconds
`define ASRC_CLK_PS 10000
// Write timing minimums, nanoseconds
`define ASRC_T_CYCLE_NS 70
`define ASRC_T_STROBE_NS 50
`define ASRC_T_ENABLE_NS 55
`define ASRC_T_ADDR_SETUP_NS 60
`define ASRC_T_DATA_SETUP_NS 30
`define ASRC_T_DATA_HOLD_NS 5
`define ASRC_T_ADDR_HOLD_NS 0
// Recovery delay after power-good, milliseconds (upper bound)
`define ASRC_T_REC_MS 200
// Cycle counts, least times round up
`define ASRC_CYC(ns) (((ns) * 1000 + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS)
`define ASRC_CYC_STROBE `ASRC_CYC(`ASRC_T_DATA_SETUP_NS > `ASRC_T_STROBE_NS ? `ASRC_T_DATA_SETUP_NS : `ASRC_T_STROBE_NS)
`define ASRC_CYC_HOLD ((`ASRC_CYC(`ASRC_T_DATA_HOLD_NS) > 0) ? `ASRC_CYC(`ASRC_T_DATA_HOLD_NS) : 1)
`define ASRC_CYC_CYCLE `ASRC_CYC(`ASRC_T_CYCLE_NS)
`define ASRC_CYC_REC ((`ASRC_T_REC_MS * 1000000) / (`ASRC_CLK_PS / 1000))
// State codes
`define ASRC_ST_RECOVER 3'h0
`define ASRC_ST_IDLE 3'h1
`define ASRC_ST_SETUP 3'h2
`define ASRC_ST_STROBE 3'h3
`define ASRC_ST_HOLD 3'h4
`define ASRC_ST_GAP 3'h5
`define ASRC_ST_READ 3'h6
`endif

/* logic/asrc_counter.v */
`default_nettype none
module asrc_counter #(
	parameter WIDTH = 32
) (
	input  wire             i_clock,
	input  wire             i_reset_n,
	input  wire             i_enable,
	input  wire             i_load,
	input  wire [WIDTH-1:0] i_value,
	output reg              o_done
);
	reg [WIDTH-1:0] count;
	always @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			// Reset starts a full count, as a fresh power-up does
			count <= i_value;
			o_done <= 1'b0;
		end
		else if (i_enable)
		begin
			if (i_load)
			begin
				count <= i_value;
				o_done <= 1'b0;
			end
			else if (count != {WIDTH{1'b0}})
			begin
				count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
				o_done <= (count == {{(WIDTH-1){1'b0}}, 1'b1});
			end
			else
				o_done <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* logic/asrc_host.v */
// What this block does
// - Address stays stable from write start to its terminating edge.
// - Terminating signal stays inactive at least zero ns before next access.
// - Data valid 30 ns before write end, held 5 ns after.
// - Cycle at least 70 ns, strobe 50 ns, enable 55 ns.
// - Address valid at least 60 ns before the terminating edge.
// - Address valid no later than the write's starting edge.
// - Output enable stays high during writes to avoid contention.
// - Accesses resume only after 40 to 200 ms recovery delay.
`default_nettype none
`include "asrc_consts.vh"
module asrc_host #(
	parameter ADDR_WIDTH = 13,
	parameter DATA_WIDTH = 8,
	parameter REC_CYCLES = `ASRC_CYC_REC
) (
	input  wire                  i_clock,
	input  wire                  i_reset_n,
	input  wire                  i_clock_enable,
	input  wire                  i_power_good,
	input  wire                  i_req_valid,
	input  wire                  i_req_write,
	input  wire [ADDR_WIDTH-1:0] i_req_addr,
	input  wire [DATA_WIDTH-1:0] i_req_data,
	output reg                   o_req_ready,
	output reg                   o_rsp_valid,
	output reg  [DATA_WIDTH-1:0] o_rsp_data,
	output reg  [ADDR_WIDTH-1:0] o_sram_addr,
	output reg                   o_chip_select_low_active_n,
	output reg                   o_chip_select_high_active,
	output reg                   o_output_enable_n,
	output reg                   o_write_strobe_n,
	input  wire [DATA_WIDTH-1:0] i_sram_data,
	output reg  [DATA_WIDTH-1:0] o_sram_data,
	output reg                   o_sram_data_oe_n
);
	// Whole clocks per minimum, rounded up; the gap fills out the cycle time
	localparam [31:0] STROBE_N   = `ASRC_CYC_STROBE;
	localparam [31:0] HOLD_N     = `ASRC_CYC_HOLD;
	localparam [31:0] CYCLE_N    = `ASRC_CYC_CYCLE;
	localparam [31:0] GAP_N      = (CYCLE_N > STROBE_N + HOLD_N) ? CYCLE_N - STROBE_N - HOLD_N : 32'h1;
	localparam [3:0]  CYC_STROBE = STROBE_N[3:0];
	localparam [3:0]  CYC_HOLD   = HOLD_N[3:0];
	localparam [3:0]  CYC_CYCLE  = CYCLE_N[3:0];
	localparam [3:0]  CYC_GAP    = GAP_N[3:0];

	reg  [2:0] state;
	reg  [3:0] timer;
	wire       rec_done;
	wire       rec_load = !i_power_good;

	// Recovery timer restarts on every power dip
	asrc_counter #(
		.WIDTH(32)
	) u_rec (
		.i_clock  (i_clock),
		.i_reset_n(i_reset_n),
		.i_enable (i_clock_enable),
		.i_load   (rec_load),
		.i_value  (REC_CYCLES),
		.o_done   (rec_done)
	);

	always @(posedge i_clock)
	begin
		if (!i_reset_n)
		begin
			state <= `ASRC_ST_RECOVER;
			timer <= 4'h0;
			o_req_ready <= 1'b0;
			o_rsp_valid <= 1'b0;
			o_rsp_data <= {DATA_WIDTH{1'b0}};
			o_sram_addr <= {ADDR_WIDTH{1'b0}};
			o_chip_select_low_active_n <= 1'b1;
			o_chip_select_high_active <= 1'b0;
			o_output_enable_n <= 1'b1;
			o_write_strobe_n <= 1'b1;
			o_sram_data <= {DATA_WIDTH{1'b0}};
			o_sram_data_oe_n <= 1'b1;
		end
		else if (i_clock_enable)
		begin
			o_rsp_valid <= 1'b0;
			// One down-counter shared by the strobe, hold, read and gap phases; recovery uses u_rec
			if (timer != 4'h0)
				timer <= timer - 4'h1;
			case (state)
				`ASRC_ST_RECOVER:
				begin
					// Enables inactive until full delay elapses
					o_chip_select_low_active_n <= 1'b1;
					o_chip_select_high_active <= 1'b0;
					o_write_strobe_n <= 1'b1;
					o_output_enable_n <= 1'b1;
					o_sram_data_oe_n <= 1'b1;
					if (rec_done && i_power_good)
					begin
						state <= `ASRC_ST_IDLE;
						o_req_ready <= 1'b1;
					end
				end
				`ASRC_ST_IDLE:
				begin
					if (!i_power_good)
					begin
						state <= `ASRC_ST_RECOVER;
						o_req_ready <= 1'b0;
					end
					else if (i_req_valid)
					begin
						o_req_ready <= 1'b0;
						// Address and data set up on the same edge as the chip selects, before the strobe edge
						o_sram_addr <= i_req_addr;
						o_chip_select_low_active_n <= 1'b0;
						o_chip_select_high_active <= 1'b1;
						if (i_req_write)
						begin
							o_sram_data <= i_req_data;
							o_sram_data_oe_n <= 1'b0;
							o_output_enable_n <= 1'b1;
							state <= `ASRC_ST_SETUP;
						end
						else
						begin
							o_output_enable_n <= 1'b0;
							// Host floats the data pins so only the device drives them
							o_sram_data_oe_n <= 1'b1;
							timer <= CYC_CYCLE - 4'h1;
							state <= `ASRC_ST_READ;
						end
					end
					else
					begin
						// Park the bus at its idle levels between requests
						o_write_strobe_n <= 1'b1;
						o_output_enable_n <= 1'b1;
						o_sram_data_oe_n <= 1'b1;
					end
				end
				`ASRC_ST_SETUP:
				begin
					// Strobe falls last, so it starts the write
					o_write_strobe_n <= 1'b0;
					timer <= CYC_STROBE - 4'h1;
					state <= `ASRC_ST_STROBE;
				end
				`ASRC_ST_STROBE:
				begin
					// Strobe rise ends the write; address and data held
					if (timer == 4'h0 || !i_power_good)
					begin
						o_write_strobe_n <= 1'b1;
						timer <= CYC_HOLD - 4'h1;
						state <= `ASRC_ST_HOLD;
					end
				end
				`ASRC_ST_HOLD:
				begin
					// One hold clock covers both the data and the address hold
					if (timer == 4'h0)
					begin
						// Data and chip selects released only after strobe rose
						o_sram_data_oe_n <= 1'b1;
						o_chip_select_low_active_n <= 1'b1;
						o_chip_select_high_active <= 1'b0;
						timer <= CYC_GAP - 4'h1;
						state <= `ASRC_ST_GAP;
					end
				end
				`ASRC_ST_READ:
				begin
					// Sampled after a full cycle so the access time has passed, or at once on supply loss
					if (timer == 4'h0 || !i_power_good)
					begin
						o_rsp_data <= i_sram_data;
						o_rsp_valid <= 1'b1;
						o_output_enable_n <= 1'b1;
						o_chip_select_low_active_n <= 1'b1;
						o_chip_select_high_active <= 1'b0;
						timer <= 4'h0;
						state <= `ASRC_ST_GAP;
					end
				end
				`ASRC_ST_GAP:
				begin
					// Terminating signals stay inactive before the next access
					if (timer == 4'h0)
					begin
						state <= i_power_good ? `ASRC_ST_IDLE : `ASRC_ST_RECOVER;
						o_req_ready <= i_power_good;
					end
				end
				default:
					state <= `ASRC_ST_RECOVER;
			endcase
			// Supply loss drops strobe and enables at once in any state;
			// data stays driven one more clock so its hold is kept
			if (!i_power_good)
			begin
				o_write_strobe_n <= 1'b1;
				o_chip_select_low_active_n <= 1'b1;
				o_chip_select_high_active <= 1'b0;
				o_output_enable_n <= 1'b1;
				o_req_ready <= 1'b0;
				state <= `ASRC_ST_RECOVER;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/asrc_host_monitor.sv */
`default_nettype none
module asrc_host_monitor #(
	parameter int REC = 20
) (
	input wire logic        i_clock,
	input wire logic        i_reset_n,
	input wire logic        i_power_good,
	input wire logic        o_req_ready,
	input wire logic [12:0] o_sram_addr,
	input wire logic        o_chip_select_low_active_n,
	input wire logic        o_output_enable_n,
	input wire logic        o_write_strobe_n,
	input wire logic [7:0]  o_sram_data,
	input wire logic        o_sram_data_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	wire ws = o_write_strobe_n;
	wire cs = o_chip_select_low_active_n;
	int  cnt;
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);
	// Cycles of good supply since the last drop, counted up to REC
	always @(posedge i_clock)
		if (!i_reset_n || !i_power_good)
			cnt <= 0;
		else if (cnt < REC)
			cnt <= cnt + 1;
	property p_addr; !ws |-> $stable(o_sram_addr); endproperty
	property p_gap; $rose(ws) |-> ws[*3]; endproperty
	property p_data; !ws || $rose(ws) |-> !o_sram_data_oe_n && $stable(o_sram_data); endproperty
	property p_width; $fell(ws) |-> (!ws)[*5]; endproperty
	property p_cycle; $fell(cs) |-> (!cs)[*7]; endproperty
	property p_setup; $fell(ws) |=> $stable(o_sram_addr)[*5]; endproperty
	property p_start; $fell(ws) |-> !cs && $stable(o_sram_addr); endproperty
	property p_oe; !ws |-> o_output_enable_n; endproperty
	property p_rec; o_req_ready |-> cnt >= REC; endproperty
	property p_rec_cs; !cs |-> cnt >= REC; endproperty
	a_addr: assert property (p_addr) else $error("address moved in write");
	a_gap: assert property (p_gap) else $error("strobe gap short");
	a_data: assert property (p_data) else $error("data not held");
	a_width: assert property (p_width) else $error("strobe pulse short");
	a_cycle: assert property (p_cycle) else $error("enable pulse short");
	a_setup: assert property (p_setup) else $error("address setup short");
	a_start: assert property (p_start) else $error("address late");
	a_oe: assert property (p_oe) else $error("output enable in write");
	a_rec: assert property (p_rec) else $error("ready before recovery");
	a_rec_cs: assert property (p_rec_cs) else $error("select before recovery");
	c_write: cover property ($fell(ws));
	c_read: cover property ($fell(o_output_enable_n));
	c_ready: cover property ($rose(o_req_ready));
endmodule
bind asrc_host asrc_host_monitor #(.REC(REC_CYCLES)) i_asrc_host_monitor (.*);
`default_nettype wire

/* tb/asrc_sram_model.sv */
`default_nettype none
module asrc_sram_model (
	input wire logic        i_power_good,
	input wire logic [12:0] i_addr,
	input wire logic        i_cs_n,
	input wire logic        i_cs,
	input wire logic        i_oe_n,
	input wire logic        i_we_n,
	input wire logic [7:0]  i_data,
	input wire logic        i_data_oe_n,
	output wire logic [7:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:8191];
	wire        sel = i_power_good && !i_cs_n && i_cs;
	wire        wr = sel && !i_we_n;
	wire #5     we_late = i_we_n;
	wire        drive = sel && i_we_n && we_late && !i_oe_n;
	always @(negedge wr)
		mem[i_addr] <= i_data;
	// Floating bus shows the inverse, never a stale match
	assign o_pin = !i_data_oe_n ? i_data : drive ? mem[i_addr] : ~i_data;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int REC = 20;
	logic        clk = 0, rst_n = 0, pg = 1, valid = 0, write = 0, ce = 1;
	logic [12:0] addr = '0;
	logic [7:0]  data = '0;
	wire  [7:0]  pin, rdata, sd;
	wire  [12:0] sa;
	wire         ready, rvalid, csn, csh, oen, wen, doen;
	int          fail_count = 0, n_tests = 0, cyc = 0;
	always #5 clk = ~clk;
	asrc_host #(.REC_CYCLES(REC)) i_asrc_host (.i_clock(clk), .i_reset_n(rst_n), .i_clock_enable(ce),
		.i_power_good(pg), .i_req_valid(valid), .i_req_write(write), .i_req_addr(addr), .i_req_data(data),
		.o_req_ready(ready), .o_rsp_valid(rvalid), .o_rsp_data(rdata), .o_sram_addr(sa),
		.o_chip_select_low_active_n(csn), .o_chip_select_high_active(csh), .o_output_enable_n(oen),
		.o_write_strobe_n(wen), .i_sram_data(pin), .o_sram_data(sd), .o_sram_data_oe_n(doen));
	asrc_sram_model i_asrc_sram_model (.i_power_good(pg), .i_addr(sa), .i_cs_n(csn), .i_cs(csh),
		.i_oe_n(oen), .i_we_n(wen), .i_data(sd), .i_data_oe_n(doen), .o_pin(pin));
	task automatic results;
		$display("fails %0d tests %0d", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Read requests compare the returned byte against d
	task automatic req(input logic wr, input logic [12:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk) #1;
		{valid, write, addr, data} = {1'b1, wr, a, d};
		while (ready !== 1'b1 && n++ < 50)
			@(posedge clk) #1;
		check(8'(ready), 8'h01);
		@(posedge clk) #1;
		valid = 0;
		n = 0;
		while (!wr && rvalid !== 1'b1 && n++ < 20)
			@(posedge clk) #1;
		if (!wr)
		begin
			check(8'(rvalid), 8'h01);
			check(8'(n), 8'h07);
			check(rdata, d);
		end
	endtask
	task automatic t_recover;
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 100)
		begin
			@(posedge clk) #1;
			n++;
		end
		check(8'(n >= REC && n <= REC + 3), 8'h01);
	endtask
	task automatic t_power;
		@(posedge clk) #1;
		pg = 0;
		repeat (3) @(posedge clk);
		#1 check(8'(ready), 8'h00);
		pg = 1;
		t_recover;
		req(0, 13'h1fff, 8'ha5);
	endtask
	// Clock enable drops mid-strobe; the write must still land
	task automatic t_freeze;
		fork
			req(1, 13'h0155, 8'h5a);
			begin
				repeat (3) @(posedge clk);
				#1 ce = 0;
				repeat (4) @(posedge clk);
				#1 ce = 1;
			end
		join
		req(0, 13'h0155, 8'h5a);
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		#1 rst_n = 1;
		t_recover;
		req(1, 13'h1fff, 8'ha5);
		req(1, 13'h0000, 8'h3c);
		req(0, 13'h1fff, 8'ha5);
		req(0, 13'h0000, 8'h3c);
		t_freeze;
		t_power;
		results;
	end
	always @(posedge clk)
		if (++cyc == 2000)
		begin
			fail_count++;
			results;
		end
endmodule
`default_nettype wire
